// File: design/foldback_pkg.sv
`default_nettype none

package foldback_pkg;

  // ==========================================================================
  // Widths
  // ==========================================================================
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 12;

  // ==========================================================================
  // Parameter addresses
  // ==========================================================================
  localparam logic [ADDR_W-1:0] ADDR_EFFECTIVE_FAULT_LEVEL = 12'h1b4;
  localparam logic [ADDR_W-1:0] ADDR_USER_FAULT_LEVEL      = 12'h1b6;
  localparam logic [ADDR_W-1:0] ADDR_WARNING_LEVEL         = 12'h1b8;
  localparam logic [ADDR_W-1:0] ADDR_FRICTION              = 12'h1ba;
  localparam logic [ADDR_W-1:0] ADDR_OVERALL_FOLDBACK      = 12'h1bc;

  // ==========================================================================
  // Values after reset
  // ==========================================================================
  localparam logic [DATA_W-1:0] RESET_WARNING_LEVEL = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RESET_FRICTION      = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RESET_READ_DATA     = 32'h0000_0000;

  // ==========================================================================
  // Foldback integrator step per loop cycle
  // ==========================================================================
  localparam logic [DATA_W-1:0] FOLDBACK_STEP = 32'h0000_0001;

  // ==========================================================================
  // Operation modes
  // ==========================================================================
  localparam logic [1:0] MODE_TORQUE   = 2'h0;
  localparam logic [1:0] MODE_VELOCITY = 2'h1;
  localparam logic [1:0] MODE_POSITION = 2'h2;

  typedef enum logic [0:0] {
    ST_RUN,
    ST_FAULT
  } supervisor_state_t;

endpackage : foldback_pkg

`default_nettype wire

// File: design/foldback_integrator.sv
`default_nettype none

module foldback_integrator
  import foldback_pkg::*;
#(
  parameter int unsigned     W    = foldback_pkg::DATA_W,
  parameter logic [W-1:0]    STEP = foldback_pkg::FOLDBACK_STEP
)
(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] actual_current,
  input  wire logic [W-1:0] continuous_current,
  input  wire logic [W-1:0] ceiling,
  output logic      [W-1:0] limit
);

  // ==========================================================================
  // Limit integrator
  // ==========================================================================
  // The limit starts at its ceiling and never wraps below zero or above it.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      limit <= ceiling;
    end
    else if (actual_current > continuous_current)
    begin
      limit <= (limit > STEP) ? limit - STEP : '0;
    end
    else if (actual_current < continuous_current)
    begin
      limit <= (limit < ceiling && ceiling - limit > STEP) ? limit + STEP : ceiling;
    end
    else if (limit > ceiling)
    begin
      limit <= ceiling;
    end
  end

endmodule : foldback_integrator

`default_nettype wire

// File: design/friction_injector.sv
`default_nettype none

module friction_injector
  import foldback_pkg::*;
#(
  parameter int unsigned W = foldback_pkg::DATA_W
)
(
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic [W-1:0]        friction_value,
  input  wire logic signed [W-1:0] position_command,
  input  wire logic [1:0]          operation_mode_select,
  output logic signed [W:0]        friction_term
);

  logic signed [W-1:0] previous_position;
  logic signed [W:0]   position_delta;

  assign position_delta = {position_command[W-1], position_command}
                          - {previous_position[W-1], previous_position};

  // ==========================================================================
  // Derivative sample
  // ==========================================================================
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      previous_position <= '0;
    end
    else
    begin
      previous_position <= position_command;
    end
  end

  // ==========================================================================
  // Signed friction term
  // ==========================================================================
  always_comb
  begin
    friction_term = '0;
    if (operation_mode_select == MODE_VELOCITY || operation_mode_select == MODE_POSITION)
    begin
      if (position_delta > 0)
      begin
        friction_term = $signed({1'b0, friction_value});
      end
      else if (position_delta < 0)
      begin
        friction_term = -$signed({1'b0, friction_value});
      end
    end
  end

endmodule : friction_injector

`default_nettype wire

// File: design/current_foldback_supervisor.sv
`default_nettype none

// Functional notes
// - Drive and motor foldback limits are computed side by side, each from its own parameters.
// - The overall foldback limit always equals the smaller of the drive and motor limits.
// - The overall foldback limit becomes the active current limit when it is the tighter one.
// - The effective fault level is the least of drive peak, motor peak and the user fault level.
// - An overall limit below the effective fault level raises a fault and disables the stage.
// - An overall limit below the warning level raises a warning and leaves the stage enabled.
// - The friction value, signed by the position command derivative, is added to the command.
// - Friction is injected only in velocity (1) and position (2) modes, never in torque (0).
// - The friction value is held between zero and the lesser of positive limit and motor peak.
// - The drive limit falls while current exceeds continuous current and rises to a ceiling below.
module current_foldback_supervisor
  import foldback_pkg::*;
#(
  parameter int unsigned W = foldback_pkg::DATA_W
)
(
  input  wire logic                           clk,
  input  wire logic                           rst,
  input  wire logic [foldback_pkg::ADDR_W-1:0] par_addr,
  input  wire logic                           par_write,
  input  wire logic                           par_read,
  input  wire logic [W-1:0]                   par_write_data,
  output logic      [W-1:0]                   par_read_data,
  output logic                                par_read_valid,
  input  wire logic [W-1:0]                   actual_current,
  input  wire logic [W-1:0]                   drive_continuous_current,
  input  wire logic [W-1:0]                   drive_foldback_ceiling,
  input  wire logic [W-1:0]                   motor_continuous_current,
  input  wire logic [W-1:0]                   motor_foldback_ceiling,
  input  wire logic [W-1:0]                   drive_peak_current,
  input  wire logic [W-1:0]                   motor_peak_current,
  input  wire logic [W-1:0]                   positive_current_limit,
  input  wire logic [1:0]                     operation_mode_select,
  input  wire logic signed [W-1:0]            position_command,
  input  wire logic signed [W-1:0]            current_command_in,
  input  wire logic                           fault_clear,
  output logic      [W-1:0]                   drive_foldback_limit,
  output logic      [W-1:0]                   motor_foldback_limit,
  output logic      [W-1:0]                   active_current_limit,
  output logic signed [W-1:0]                 current_command_out,
  output logic                                foldback_fault,
  output logic                                foldback_warning,
  output logic                                power_stage_enable
);

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [W-1:0] min2(input logic [W-1:0] a, input logic [W-1:0] b);
    min2 = (a < b) ? a : b;
  endfunction : min2

  function automatic logic [W-1:0] clamp_friction(input logic [W-1:0] value,
                                                  input logic [W-1:0] ceiling);
    clamp_friction = min2(value, ceiling);
  endfunction : clamp_friction

  // ==========================================================================
  // Declarations
  // ==========================================================================
  logic [W-1:0]        drive_limit_raw;
  logic [W-1:0]        motor_limit_raw;
  logic [W-1:0]        overall_foldback_limit;
  logic [W-1:0]        effective_fault_level;
  logic [W-1:0]        user_fault_level;
  logic [W-1:0]        foldback_warning_level;
  logic [W-1:0]        friction_compensation_value;
  logic [W-1:0]        friction_ceiling;
  logic [W-1:0]        friction_applied;
  logic signed [W:0]   friction_term;
  logic signed [W+1:0] command_sum;
  logic signed [W+1:0] command_high;
  logic signed [W+1:0] command_low;
  logic                fault_condition;
  logic                warning_condition;
  supervisor_state_t   state;
  supervisor_state_t   next_state;

  // ==========================================================================
  // Foldback integrators
  // ==========================================================================
  // drive-side algorithm
  foldback_integrator #(
    .W    (W),
    .STEP (W'(FOLDBACK_STEP))
  ) drive_integrator (
    .clk                (clk),
    .rst                (rst),
    .actual_current     (actual_current),
    .continuous_current (drive_continuous_current),
    .ceiling            (drive_foldback_ceiling),
    .limit              (drive_limit_raw)
  );

  foldback_integrator #(
    .W    (W),
    .STEP (W'(FOLDBACK_STEP))
  ) motor_integrator (
    .clk                (clk),
    .rst                (rst),
    .actual_current     (actual_current),
    .continuous_current (motor_continuous_current),
    .ceiling            (motor_foldback_ceiling),
    .limit              (motor_limit_raw)
  );

  // ==========================================================================
  // Overall limit and fault level
  // ==========================================================================
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      drive_foldback_limit   <= '0;
      motor_foldback_limit   <= '0;
      overall_foldback_limit <= '0;
      effective_fault_level  <= '0;
    end
    else
    begin
      drive_foldback_limit   <= drive_limit_raw;
      motor_foldback_limit   <= motor_limit_raw;
      overall_foldback_limit <= min2(drive_limit_raw, motor_limit_raw);
      effective_fault_level  <= min2(min2(drive_peak_current, motor_peak_current),
                                     user_fault_level);
    end
  end

  // ==========================================================================
  // Active current limit
  // ==========================================================================
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      active_current_limit <= '0;
    end
    else
    begin
      active_current_limit <= min2(positive_current_limit, overall_foldback_limit);
    end
  end

  // ==========================================================================
  // Fault and warning supervision
  // ==========================================================================
  // compare registered values
  assign fault_condition   = overall_foldback_limit < effective_fault_level;
  assign warning_condition = overall_foldback_limit < foldback_warning_level;

  always_comb
  begin
    next_state = state;
    case (state)
      ST_RUN:
      begin
        if (fault_condition)
        begin
          next_state = ST_FAULT;
        end
      end
      ST_FAULT:
      begin
        // only a clear with the cause gone
        if (fault_clear && !fault_condition)
        begin
          next_state = ST_RUN;
        end
      end
      default:
      begin
        next_state = ST_FAULT;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state <= ST_RUN;
    end
    else
    begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      foldback_fault     <= 1'b0;
      power_stage_enable <= 1'b0;
    end
    else
    begin
      foldback_fault     <= (next_state == ST_FAULT);
      power_stage_enable <= (next_state == ST_RUN);
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      foldback_warning <= 1'b0;
    end
    else
    begin
      foldback_warning <= warning_condition;
    end
  end

  // ==========================================================================
  // Parameter writes
  // ==========================================================================
  assign friction_ceiling = min2(positive_current_limit, motor_peak_current);

  // The user fault level powers up at the drive peak current.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      user_fault_level <= drive_peak_current;
    end
    else if (par_write && par_addr == ADDR_USER_FAULT_LEVEL)
    begin
      user_fault_level <= par_write_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      foldback_warning_level <= RESET_WARNING_LEVEL;
    end
    else if (par_write && par_addr == ADDR_WARNING_LEVEL)
    begin
      foldback_warning_level <= par_write_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      friction_compensation_value <= RESET_FRICTION;
    end
    else if (par_write && par_addr == ADDR_FRICTION)
    begin
      friction_compensation_value <= clamp_friction(par_write_data, friction_ceiling);
    end
  end

  // ==========================================================================
  // Parameter reads
  // ==========================================================================
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      par_read_data  <= RESET_READ_DATA;
      par_read_valid <= 1'b0;
    end
    else
    begin
      par_read_valid <= par_read;
      if (par_read)
      begin
        case (par_addr)
          ADDR_EFFECTIVE_FAULT_LEVEL: par_read_data <= effective_fault_level;
          ADDR_USER_FAULT_LEVEL:      par_read_data <= user_fault_level;
          ADDR_WARNING_LEVEL:         par_read_data <= foldback_warning_level;
          ADDR_FRICTION:              par_read_data <= friction_compensation_value;
          ADDR_OVERALL_FOLDBACK:      par_read_data <= overall_foldback_limit;
          default:                    par_read_data <= RESET_READ_DATA;
        endcase
      end
    end
  end

  // ==========================================================================
  // Friction injection and command limiting
  // ==========================================================================
  // confined again on use, since the limits move
  assign friction_applied = clamp_friction(friction_compensation_value, friction_ceiling);

  friction_injector #(
    .W (W)
  ) injector (
    .clk                   (clk),
    .rst                   (rst),
    .friction_value        (friction_applied),
    .position_command      (position_command),
    .operation_mode_select (operation_mode_select),
    .friction_term         (friction_term)
  );

  assign command_sum  = {{2{current_command_in[W-1]}}, current_command_in}
                        + {friction_term[W], friction_term};
  assign command_high = $signed({2'b00, active_current_limit});
  assign command_low  = -command_high;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      current_command_out <= '0;
    end
    else if (command_sum > command_high)
    begin
      current_command_out <= command_high[W-1:0];
    end
    else if (command_sum < command_low)
    begin
      current_command_out <= command_low[W-1:0];
    end
    else
    begin
      current_command_out <= command_sum[W-1:0];
    end
  end

endmodule : current_foldback_supervisor

`default_nettype wire

// File: testbench/foldback_properties.sv
`default_nettype none

module foldback_properties #(
  parameter int unsigned W = 32
)
(
  input wire logic                clk,
  input wire logic                rst,
  input wire logic                par_read,
  input wire logic                par_read_valid,
  input wire logic [W-1:0]        actual_current,
  input wire logic [W-1:0]        drive_continuous_current,
  input wire logic [W-1:0]        motor_continuous_current,
  input wire logic [W-1:0]        positive_current_limit,
  input wire logic [1:0]          operation_mode_select,
  input wire logic signed [W-1:0] current_command_in,
  input wire logic                fault_clear,
  input wire logic [W-1:0]        drive_foldback_limit,
  input wire logic [W-1:0]        motor_foldback_limit,
  input wire logic [W-1:0]        active_current_limit,
  input wire logic signed [W-1:0] current_command_out,
  input wire logic                foldback_fault,
  input wire logic                foldback_warning,
  input wire logic                power_stage_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [W-1:0]      exp_active;
  logic signed [W:0] lim;
  logic signed [W:0] exp_cmd;

  // =========================================================================
  // Expected values
  // =========================================================================
  always_comb
  begin
    exp_active = (drive_foldback_limit < motor_foldback_limit) ?
                 drive_foldback_limit : motor_foldback_limit;
    if (positive_current_limit < exp_active)
      exp_active = positive_current_limit;
    lim = {1'b0, active_current_limit};
    exp_cmd = {current_command_in[W-1], current_command_in};
    if (exp_cmd > lim)
      exp_cmd = lim;
    else if (exp_cmd < -lim)
      exp_cmd = -lim;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // =========================================================================
  // Sequences and assertions
  // =========================================================================
  sequence quiet_limits;
    ($stable(drive_foldback_limit) && $stable(motor_foldback_limit) &&
     $stable(positive_current_limit)) [*3];
  endsequence
  sequence quiet_torque;
    (operation_mode_select == 2'h0 && power_stage_enable && $stable(current_command_in) &&
     $stable(active_current_limit)) [*3];
  endsequence
  sequence over_drive_rating;
    (actual_current > drive_continuous_current) [*3];
  endsequence
  sequence under_motor_rating;
    (actual_current < motor_continuous_current) [*3];
  endsequence

  fault_stage_off_a: assert property (foldback_fault |-> !power_stage_enable)
    else $error("power stage enabled during a foldback fault");
  fault_latch_a: assert property (foldback_fault && !fault_clear |=> foldback_fault)
    else $error("foldback fault dropped without a clear");
  warn_keeps_stage_a: assert property (foldback_warning && !foldback_fault |-> power_stage_enable)
    else $error("warning alone disabled the power stage");
  read_answer_a: assert property (par_read |=> par_read_valid)
    else $error("read not answered one cycle later");
  read_quiet_a: assert property (!par_read |=> !par_read_valid)
    else $error("read valid without a read");
  active_min_a: assert property (quiet_limits |-> active_current_limit == exp_active)
    else $error("active limit is not the tightest limit");
  torque_cmd_a: assert property (quiet_torque |-> current_command_out == exp_cmd[W-1:0])
    else $error("command altered in torque mode");
  drive_fall_a: assert property (over_drive_rating |->
                                 drive_foldback_limit <= $past(drive_foldback_limit))
    else $error("drive limit rose under overload");
  motor_rise_a: assert property (under_motor_rating |->
                                 motor_foldback_limit >= $past(motor_foldback_limit))
    else $error("motor limit fell under light load");
endmodule : foldback_properties

bind current_foldback_supervisor foldback_properties #(.W(W)) u_foldback_properties (
  .clk(clk), .rst(rst), .par_read(par_read), .par_read_valid(par_read_valid),
  .actual_current(actual_current), .drive_continuous_current(drive_continuous_current),
  .motor_continuous_current(motor_continuous_current),
  .positive_current_limit(positive_current_limit),
  .operation_mode_select(operation_mode_select), .current_command_in(current_command_in),
  .fault_clear(fault_clear), .drive_foldback_limit(drive_foldback_limit),
  .motor_foldback_limit(motor_foldback_limit), .active_current_limit(active_current_limit),
  .current_command_out(current_command_out), .foldback_fault(foldback_fault),
  .foldback_warning(foldback_warning), .power_stage_enable(power_stage_enable)
);

`default_nettype wire

// File: testbench/power_stage_model.sv
`default_nettype none

module power_stage_model (
  input  wire logic        power_stage_enable,
  input  wire logic [31:0] load_current,
  output logic      [31:0] actual_current
);
  timeunit 1ns;
  timeprecision 1ps;
  // A disabled stage carries no current, whatever load the bench asks for.
  assign actual_current = power_stage_enable ? load_current : 32'h0000_0000;
endmodule : power_stage_model

`default_nettype wire

// File: testbench/tb_top.sv
`default_nettype none

module tb_top;
  import foldback_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIMIT = 3000;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic [ADDR_W-1:0]  par_addr = '0;
  logic               par_write = 1'b0;
  logic               par_read = 1'b0;
  logic [31:0]        par_write_data = '0;
  logic [31:0]        par_read_data;
  logic               par_read_valid;
  logic [31:0]        actual_current;
  logic [31:0]        load_current = 32'h0;
  logic [31:0]        drive_peak = 32'h28;
  logic [31:0]        motor_peak = 32'h2c;
  logic [31:0]        pcl = 32'h2d;
  logic [1:0]         mode = 2'h0;
  logic signed [31:0] pos = '0;
  logic signed [31:0] cmd_in = '0;
  logic signed [31:0] cmd_out;
  logic               fault_clear = 1'b0;
  logic [31:0]        dfl;
  logic [31:0]        mfl;
  logic [31:0]        act;
  logic               fault;
  logic               warn;
  logic               enable;
  logic [31:0]        rd_val;
  int                 fails = 0;
  int                 n_compared = 0;
  int                 cyc = 0;

  current_foldback_supervisor u_current_foldback_supervisor (
    .clk(clk), .rst(rst), .par_addr(par_addr), .par_write(par_write), .par_read(par_read),
    .par_write_data(par_write_data), .par_read_data(par_read_data),
    .par_read_valid(par_read_valid), .actual_current(actual_current),
    .drive_continuous_current(32'h0000_000a), .drive_foldback_ceiling(32'h0000_0032),
    .motor_continuous_current(32'h0000_000f), .motor_foldback_ceiling(32'h0000_003c),
    .drive_peak_current(drive_peak), .motor_peak_current(motor_peak),
    .positive_current_limit(pcl), .operation_mode_select(mode), .position_command(pos),
    .current_command_in(cmd_in), .fault_clear(fault_clear), .drive_foldback_limit(dfl),
    .motor_foldback_limit(mfl), .active_current_limit(act), .current_command_out(cmd_out),
    .foldback_fault(fault), .foldback_warning(warn), .power_stage_enable(enable)
  );

  power_stage_model u_power_stage_model (
    .power_stage_enable(enable), .load_current(load_current), .actual_current(actual_current)
  );

  always #20 clk = ~clk;

  // =========================================================================
  // Shared tasks
  // =========================================================================
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic cycles(input int n);
    repeat (n)
    begin
      @(posedge clk);
      #1;
    end
  endtask : cycles

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    par_addr = a;
    par_write_data = d;
    par_write = 1'b1;
    cycles(1);
    par_write = 1'b0;
    cycles(1);
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a);
    par_addr = a;
    par_read = 1'b1;
    cycles(1);
    par_read = 1'b0;
    chk("read valid", 32'h1, 32'(par_read_valid));
    rd_val = par_read_data;
    cycles(1);
  endtask : rd

  // =========================================================================
  // Scenarios
  // =========================================================================
  task automatic t_regs();
    rd(ADDR_WARNING_LEVEL);
    chk("warning level", RESET_WARNING_LEVEL, rd_val);
    rd(ADDR_FRICTION);
    chk("friction", RESET_FRICTION, rd_val);
    rd(ADDR_USER_FAULT_LEVEL);
    chk("user fault level", 32'h28, rd_val);
    wr(ADDR_EFFECTIVE_FAULT_LEVEL, 32'h5);
    wr(ADDR_OVERALL_FOLDBACK, 32'h5);
    rd(ADDR_EFFECTIVE_FAULT_LEVEL);
    chk("effective fault level", 32'h28, rd_val);
    rd(ADDR_OVERALL_FOLDBACK);
    chk("overall limit", 32'h32, rd_val);
    rd(12'h1c0);
    chk("unmapped read", RESET_READ_DATA, rd_val);
    motor_peak = 32'h21;
    cycles(2);
    rd(ADDR_EFFECTIVE_FAULT_LEVEL);
    chk("effective fault level", 32'h21, rd_val);
    motor_peak = 32'h2c;
    wr(ADDR_WARNING_LEVEL, 32'h2f);
    rd(ADDR_WARNING_LEVEL);
    chk("warning level", 32'h2f, rd_val);
    $display("test registers done");
  endtask : t_regs

  task automatic t_friction();
    wr(ADDR_FRICTION, 32'h64);
    rd(ADDR_FRICTION);
    chk("friction clamp", 32'h2c, rd_val);
    wr(ADDR_FRICTION, 32'h5);
    cmd_in = 32'sd10;
    for (int m = 0; m < 3; m++)
      for (int d = -1; d < 2; d++)
      begin
        mode = m[1:0];
        repeat (4)
        begin
          cycles(1);
          pos = pos + d;
        end
        chk("command out", 32'(10 + ((m == 0) ? 0 : 5 * d)), cmd_out);
      end
    mode = 2'h0;
    cmd_in = '0;
    cycles(4);
    $display("test friction done");
  endtask : t_friction

  task automatic t_foldback();
    wr(ADDR_USER_FAULT_LEVEL, 32'h23);
    load_current = 32'h37;
    for (int i = 0; i < 40 && warn !== 1'b1; i++) cycles(1);
    chk("warning", 32'h1, 32'(warn));
    chk("stage enable", 32'h1, 32'(enable));
    for (int i = 0; i < 40 && dfl > 32'h27; i++) cycles(1);
    load_current = 32'ha;
    cycles(4);
    chk("drive limit", 32'h26, dfl);
    chk("motor above drive", 32'h1, 32'(mfl > dfl));
    chk("active limit", 32'h26, act);
    rd(ADDR_OVERALL_FOLDBACK);
    chk("overall limit", 32'h26, rd_val);
    pcl = 32'h1e;
    cycles(4);
    chk("active limit", 32'h1e, act);
    pcl = 32'h2d;
    chk("no fault", 32'h0, 32'(fault));
    load_current = 32'h37;
    for (int i = 0; i < 40 && fault !== 1'b1; i++) cycles(1);
    chk("fault", 32'h1, 32'(fault));
    chk("stage enable", 32'h0, 32'(enable));
    fault_clear = 1'b1;
    cycles(1);
    chk("fault held", 32'h1, 32'(fault));
    for (int i = 0; i < 20 && fault !== 1'b0; i++) cycles(1);
    cycles(1);
    chk("fault cleared", 32'h0, 32'(fault));
    chk("stage enable", 32'h1, 32'(enable));
    fault_clear = 1'b0;
    wr(ADDR_USER_FAULT_LEVEL, 32'h0);
    rd(ADDR_EFFECTIVE_FAULT_LEVEL);
    chk("effective fault level", 32'h0, rd_val);
    cycles(60);
    chk("no fault at zero level", 32'h0, 32'(fault));
    load_current = 32'h0;
    wr(ADDR_WARNING_LEVEL, 32'h5);
    cycles(12);
    chk("no warning", 32'h0, 32'(warn));
    $display("test foldback done");
  endtask : t_foldback

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      fails++;
      end_sim();
    end
  end

  initial
  begin
    repeat (20) @(posedge clk);
    #1;
    rst = 1'b0;
    cycles(2);
    t_regs();
    t_friction();
    t_foldback();
    end_sim();
  end
endmodule : tb_top

`default_nettype wire
